// ===== common/wdt_pkg.sv
// package of watchdog register map, field layouts and timing counts
package wdt_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] WDT_OFF_CTRL = 8'h00;
  localparam logic [7:0] WDT_OFF_STATUS = 8'h04;
  localparam logic [7:0] WDT_OFF_MASK = 8'h08;
  localparam logic [7:0] WDT_OFF_COUNT = 8'h0c;

  // control register field positions
  localparam int WDT_CTRL_CLEAR_BIT = 0;
  localparam int WDT_CTRL_IE_BIT = 1;
  localparam int WDT_CTRL_WAKE_BIT = 4;
  localparam int WDT_CTRL_EN_BIT = 7;
  localparam int WDT_CTRL_ISEL_LSB = 8;
  localparam int WDT_CTRL_ISEL_MSB = 10;

  // status and mask field positions
  localparam int WDT_ST_TMO_BIT = 0;
  localparam int WDT_ST_RST_BIT = 1;
  localparam int WDT_ST_WAKE_BIT = 2;

  // counter geometry and timing in watchdog clocks
  localparam int WDT_CNT_W = 19;
  localparam int WDT_ISEL_W = 3;
  localparam int WDT_EXP_BASE = 4;
  localparam int WDT_EXP_STEP = 2;
  localparam logic [18:0] WDT_DELAY_TICKS = 19'h00400;
  localparam int WDT_RST_W = 7;
  localparam logic [6:0] WDT_RST_TICKS = 7'h40;

  // reset values
  localparam logic [18:0] WDT_CNT_RESET = 19'h00000;
  localparam logic [6:0] WDT_RST_CNT_RESET = 7'h00;
  localparam logic [31:0] WDT_RDATA_RESET = 32'h00000000;

  // control register fields as software sees them
  typedef struct packed {
    logic [2:0] isel;
    logic enable;
    logic wake_en;
    logic int_en;
    logic clear;
  } wdt_ctrl_type;

  // sticky event bits, shared layout of status and mask
  typedef struct packed {
    logic wake;
    logic rst;
    logic tmo;
  } wdt_evt_type;

  localparam wdt_ctrl_type WDT_CTRL_RESET = '{isel: 3'h0, enable: 1'b0, wake_en: 1'b0, int_en: 1'b0, clear: 1'b0};
  localparam wdt_evt_type WDT_EVT_RESET = '{wake: 1'b0, rst: 1'b0, tmo: 1'b0};

endpackage

// ===== verif/wdt_top_tb.sv
// self-checking bench for the watchdog block, driven over apb
`timescale 1ns/1ps
module wdt_top_tb
  import wdt_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic watchdog_clock = 1'b0;
  logic power_down = 1'b0;
  logic irq_q;
  logic cpu_reset_q;
  logic cpu_wakeup_q;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int total_checks = 0;

  wdt_top wdt_top_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .watchdog_clock(watchdog_clock),
    .power_down(power_down),
    .irq_q(irq_q),
    .cpu_reset_q(cpu_reset_q),
    .cpu_wakeup_q(cpu_wakeup_q)
  );

  // 125 mhz system clock
  always #4 pclk = ~pclk;

  task automatic summarize();
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request stands until pready is seen high at a rising edge,
  // data and error are taken at that edge; only the hang guard ends a missing answer
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // watchdog clock periods of 8 pclk, high for 4 and low for 4, then time for the synchroniser to settle
  task automatic tick(input int n);
    repeat (n)
    begin
      watchdog_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      watchdog_clock <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 32'h10, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 32'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    tick(5);
    apb(1'b0, {24'h0, WDT_OFF_COUNT}, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, {24'h0, WDT_OFF_MASK}, 32'h7);
    // intervals 2^4..2^10; larger codes would run too long at this tick rate
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, {24'h0, WDT_OFF_CTRL}, 32'h83 | (c << 8));
      apb(1'b1, {24'h0, WDT_OFF_STATUS}, 32'h7);
      tick((1 << (4 + 2 * c)) - 1);
      apb(1'b0, {24'h0, WDT_OFF_COUNT}, 32'h0);
      chk(rd, (1 << (4 + 2 * c)) - 1);
      chk({31'h0, irq_q}, 32'h0);
      tick(1);
      apb(1'b0, {24'h0, WDT_OFF_STATUS}, 32'h0);
      chk(rd, 32'h1);
      chk({31'h0, irq_q}, 32'h1);
    end
    // the long codes cannot run out here; at least each one must be stored
    for (int c = 4; c < 8; c++)
    begin
      apb(1'b1, {24'h0, WDT_OFF_CTRL}, 32'h80 | (c << 8));
      apb(1'b0, {24'h0, WDT_OFF_CTRL}, 32'h0);
      chk(rd, 32'h80 | (c << 8));
    end
    apb(1'b1, {24'h0, WDT_OFF_CTRL}, 32'h81);
    apb(1'b0, {24'h0, WDT_OFF_CTRL}, 32'h0);
    chk(rd, 32'h80);
    apb(1'b0, {24'h0, WDT_OFF_COUNT}, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, {24'h0, WDT_OFF_STATUS}, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq_q}, 32'h0);
    // a clear 40 ticks before the deadline restarts the whole budget
    tick(1000);
    apb(1'b1, {24'h0, WDT_OFF_CTRL}, 32'h81);
    tick(1039);
    chk({31'h0, cpu_reset_q}, 32'h0);
    tick(1);
    chk({31'h0, cpu_reset_q}, 32'h1);
    apb(1'b0, {24'h0, WDT_OFF_STATUS}, 32'h0);
    chk(rd, 32'h3);
    chk({31'h0, irq_q}, 32'h1);
    tick(63);
    chk({31'h0, cpu_reset_q}, 32'h1);
    tick(1);
    chk({31'h0, cpu_reset_q}, 32'h0);
    apb(1'b0, {24'h0, WDT_OFF_STATUS}, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, {24'h0, WDT_OFF_COUNT}, 32'h0);
    chk(rd, 32'h0);
    // wakeup from power-down on a timeout
    apb(1'b1, {24'h0, WDT_OFF_STATUS}, 32'h7);
    apb(1'b1, {24'h0, WDT_OFF_CTRL}, 32'h91);
    power_down <= 1'b1;
    tick(16);
    chk({31'h0, cpu_wakeup_q}, 32'h1);
    apb(1'b0, {24'h0, WDT_OFF_STATUS}, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, {24'h0, WDT_OFF_STATUS}, 32'h4);
    apb(1'b0, {24'h0, WDT_OFF_STATUS}, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, cpu_wakeup_q}, 32'h0);
    summarize();
  end

  // hang guard, well above the roughly 30000 cycles the sequence needs
  initial
  begin
    #(100000 * 8);
    failures++;
    summarize();
  end
endmodule

// ===== verilog/wdt_sync3.sv
// three-stage synchroniser turning a slow clock pin into a rising-edge tick
`timescale 1ns/1ps
module wdt_sync3
  import wdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic tick_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // shift chain; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree, filtering one-cycle glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      if (s2_q == s3_q)
      begin
        level_q <= s3_q;
      end
      tick_q <= (s2_q == s3_q) && s3_q && !level_q;
    end
  end

endmodule

// ===== verilog/wdt_top.sv
// watchdog timer with interval interrupt, delayed cpu reset and wakeup, apb slave
// Functional notes
// - 19-bit up counter advances per enabled tick
// - control bit 7 enables and starts counting
// - interval reached sets flag; interrupt needs enable
// - software writes bit 0; hardware clears counter, bit
// - bits 10:8 pick interval 2^4..2^18 clocks
// - reset deadline is interval plus 1024 clocks
// - uncleared at deadline: set reset flag, reset cpu
// - cpu reset held 64 watchdog clocks, then released
// - reset flag survives watchdog reset for polling
// - timeout event can wake cpu from power-down
`timescale 1ns/1ps
module wdt_top
  import wdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_clock,
  input wire logic power_down,
  output logic irq_q,
  output logic cpu_reset_q,
  output logic cpu_wakeup_q
);

  wdt_ctrl_type ctrl_q;
  wdt_evt_type status_q;
  wdt_evt_type mask_q;
  logic [WDT_CNT_W-1:0] cnt_q;
  logic [WDT_RST_W-1:0] rst_cnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wdt_tick;
  logic [WDT_CNT_W-1:0] interval_w;
  logic [WDT_CNT_W-1:0] deadline_w;
  logic run_tick;
  logic reach_tmo;
  logic reach_dead;
  logic wr_acc;
  logic [7:0] addr_w;
  logic addr_ok;
  wdt_evt_type set_evt;
  wdt_evt_type w1c_evt;
  logic [31:0] rd_mux;

  // slow watchdog clock is sampled as a pin; each rising edge is one tick
  wdt_sync3 u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(watchdog_clock),
    .tick_q(wdt_tick)
  );

  // selected interval is 2^(4+2*sel); deadline adds the fixed delay
  assign interval_w = WDT_CNT_W'(19'h00001 << (WDT_EXP_BASE + WDT_EXP_STEP * int'(ctrl_q.isel)));
  assign deadline_w = interval_w + WDT_DELAY_TICKS;

  // counting only while enabled and not holding the cpu in reset
  assign run_tick = wdt_tick && ctrl_q.enable && !ctrl_q.clear && !cpu_reset_q;
  assign reach_tmo = run_tick && (cnt_q == interval_w - 19'h00001);
  assign reach_dead = run_tick && (cnt_q == deadline_w - 19'h00001);

  // apb decode; writes take effect on the access edge where pready is high
  assign addr_w = paddr[7:0];
  assign addr_ok = (paddr[31:8] == 24'h000000) && ((addr_w == WDT_OFF_CTRL) || (addr_w == WDT_OFF_STATUS) ||
                   (addr_w == WDT_OFF_MASK) || (addr_w == WDT_OFF_COUNT));
  assign wr_acc = psel && penable && pready_q && pwrite && addr_ok;

  // event sources and write-one-to-clear requests
  always_comb
  begin
    set_evt.tmo = reach_tmo;
    set_evt.rst = reach_dead;
    set_evt.wake = reach_tmo && ctrl_q.wake_en && power_down;
    w1c_evt = WDT_EVT_RESET;
    if (wr_acc && (addr_w == WDT_OFF_STATUS))
    begin
      w1c_evt.tmo = pwdata[WDT_ST_TMO_BIT];
      w1c_evt.rst = pwdata[WDT_ST_RST_BIT];
      w1c_evt.wake = pwdata[WDT_ST_WAKE_BIT];
    end
  end

  // control register; clear bit self-clears one cycle after software sets it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= WDT_CTRL_RESET;
    end
    else if (wr_acc && (addr_w == WDT_OFF_CTRL))
    begin
      ctrl_q.enable <= pwdata[WDT_CTRL_EN_BIT];
      ctrl_q.int_en <= pwdata[WDT_CTRL_IE_BIT];
      ctrl_q.wake_en <= pwdata[WDT_CTRL_WAKE_BIT];
      ctrl_q.isel <= pwdata[WDT_CTRL_ISEL_MSB:WDT_CTRL_ISEL_LSB];
      ctrl_q.clear <= pwdata[WDT_CTRL_CLEAR_BIT] || ctrl_q.clear;
    end
    else if (ctrl_q.clear)
    begin
      ctrl_q.clear <= 1'b0;
    end
  end

  // up counter; a clear or a watchdog reset restarts timing from zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= WDT_CNT_RESET;
    end
    else if (ctrl_q.clear || cpu_reset_q)
    begin
      cnt_q <= WDT_CNT_RESET;
    end
    else if (reach_dead)
    begin
      cnt_q <= WDT_CNT_RESET;
    end
    else if (run_tick)
    begin
      cnt_q <= cnt_q + 19'h00001;
    end
  end

  // cpu reset pulse, counted in watchdog ticks rather than pclk cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_reset_q <= 1'b0;
      rst_cnt_q <= WDT_RST_CNT_RESET;
    end
    else if (reach_dead)
    begin
      cpu_reset_q <= 1'b1;
      rst_cnt_q <= WDT_RST_CNT_RESET;
    end
    else if (cpu_reset_q && wdt_tick)
    begin
      if (rst_cnt_q == WDT_RST_TICKS - 7'h01)
      begin
        cpu_reset_q <= 1'b0;
        rst_cnt_q <= WDT_RST_CNT_RESET;
      end
      else
      begin
        rst_cnt_q <= rst_cnt_q + 7'h01;
      end
    end
  end

  // sticky flags; a set in the same cycle as its clear wins.
  // cpu_reset_q does not touch them, so the reset flag outlives the cpu reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= WDT_EVT_RESET;
    end
    else
    begin
      status_q.tmo <= set_evt.tmo || (status_q.tmo && !w1c_evt.tmo);
      status_q.rst <= set_evt.rst || (status_q.rst && !w1c_evt.rst);
      status_q.wake <= set_evt.wake || (status_q.wake && !w1c_evt.wake);
    end
  end

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q <= WDT_EVT_RESET;
    end
    else if (wr_acc && (addr_w == WDT_OFF_MASK))
    begin
      mask_q.tmo <= pwdata[WDT_ST_TMO_BIT];
      mask_q.rst <= pwdata[WDT_ST_RST_BIT];
      mask_q.wake <= pwdata[WDT_ST_WAKE_BIT];
    end
  end

  // interrupt output; the timeout flag needs the interrupt enable bit as well
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= (status_q.tmo && mask_q.tmo && ctrl_q.int_en) ||
               (status_q.rst && mask_q.rst) || (status_q.wake && mask_q.wake);
    end
  end

  // wakeup level stays high until software clears the wake flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_wakeup_q <= 1'b0;
    end
    else
    begin
      cpu_wakeup_q <= set_evt.wake || (cpu_wakeup_q && status_q.wake && !w1c_evt.wake);
    end
  end

  // read data selection; reserved bits read as zero
  always_comb
  begin
    rd_mux = WDT_RDATA_RESET;
    case (addr_w)
      WDT_OFF_CTRL:
      begin
        rd_mux[WDT_CTRL_CLEAR_BIT] = ctrl_q.clear;
        rd_mux[WDT_CTRL_IE_BIT] = ctrl_q.int_en;
        rd_mux[WDT_CTRL_WAKE_BIT] = ctrl_q.wake_en;
        rd_mux[WDT_CTRL_EN_BIT] = ctrl_q.enable;
        rd_mux[WDT_CTRL_ISEL_MSB:WDT_CTRL_ISEL_LSB] = ctrl_q.isel;
      end
      WDT_OFF_STATUS:
      begin
        rd_mux[WDT_ST_TMO_BIT] = status_q.tmo;
        rd_mux[WDT_ST_RST_BIT] = status_q.rst;
        rd_mux[WDT_ST_WAKE_BIT] = status_q.wake;
      end
      WDT_OFF_MASK:
      begin
        rd_mux[WDT_ST_TMO_BIT] = mask_q.tmo;
        rd_mux[WDT_ST_RST_BIT] = mask_q.rst;
        rd_mux[WDT_ST_WAKE_BIT] = mask_q.wake;
      end
      WDT_OFF_COUNT:
      begin
        rd_mux[WDT_CNT_W-1:0] = cnt_q;
      end
      default:
      begin
        rd_mux = WDT_RDATA_RESET;
      end
    endcase
  end

  // apb answer registered in the setup cycle so every output is a flop; no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= WDT_RDATA_RESET;
    end
    else
    begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite)
      begin
        prdata_q <= addr_ok ? rd_mux : WDT_RDATA_RESET;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // assertions guarding the timing relations

  AST_CNT_ADV: assert property (@(posedge pclk) disable iff (!presetn)
    run_tick && !reach_dead |=> cnt_q == $past(cnt_q) + 19'h00001)
    else $error("counter did not advance on an enabled tick");

  AST_EN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.enable && !ctrl_q.clear && !cpu_reset_q |=> cnt_q == $past(cnt_q))
    else $error("counter moved while disabled");

  AST_TMO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    reach_tmo |=> status_q.tmo ##1 (irq_q == ($past(mask_q.tmo) && $past(ctrl_q.int_en)) || irq_q))
    else $error("timeout flag or interrupt missing");

  AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_q) && !$past(status_q.rst && mask_q.rst) && !$past(status_q.wake && mask_q.wake)
    |-> $past(ctrl_q.int_en) && $past(status_q.tmo))
    else $error("interrupt raised without enable");

  AST_CLR_SELF: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.clear && !wr_acc |=> !ctrl_q.clear && cnt_q == WDT_CNT_RESET)
    else $error("clear bit did not self clear with counter reset");

  AST_INTERVAL: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_q.tmo) |-> $past(cnt_q) + 19'h00001 == (19'h00001 << (4 + 2 * int'($past(ctrl_q.isel)))))
    else $error("timeout flag at wrong interval");

  AST_DEADLINE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cpu_reset_q) |-> $past(cnt_q) + 19'h00001 == $past(interval_w) + 19'h00400)
    else $error("cpu reset not at interval plus delay");

  AST_RST_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cpu_reset_q) |-> status_q.rst)
    else $error("cpu reset without reset flag");

  AST_RST_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cpu_reset_q) |-> $past(rst_cnt_q) == WDT_RST_TICKS - 7'h01 && $past(wdt_tick))
    else $error("cpu reset released after wrong tick count");

  AST_FLAG_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    status_q.rst && !w1c_evt.rst |=> status_q.rst)
    else $error("reset flag lost without software clear");

  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    reach_tmo && ctrl_q.wake_en && power_down |=> cpu_wakeup_q && status_q.wake)
    else $error("wakeup not raised on timeout in power-down");

  AST_RST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_reset_q && !(wdt_tick && rst_cnt_q == WDT_RST_TICKS - 7'h01) |=> cpu_reset_q)
    else $error("cpu reset released before its last tick");

  AST_CNT_IN_RST: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_reset_q |=> cnt_q == WDT_CNT_RESET)
    else $error("counter moved while the cpu was held in reset");

  AST_IRQ_RST: assert property (@(posedge pclk) disable iff (!presetn)
    status_q.rst && mask_q.rst |=> irq_q)
    else $error("unmasked reset flag raised no interrupt");

  AST_WAKE_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_wakeup_q && !w1c_evt.wake |=> cpu_wakeup_q)
    else $error("wakeup dropped without a software clear");

endmodule
